// *** rtl/acl_router.sv ***
// word clock lock control, transmitter broadcast select and octal routing
// assumes bus strobes come from another clock and are held for >= 4 cycles;
// receivers and transmitters are clocked from the bit clocks made here
//
// Functional notes
// - lock bit 1 high enters seek mode; it stays until the bit clears.
// - lock bit 0 high drives receiver clocks; low leaves them undriven.
// - one address selects all four transmitters at once.
// - octal bits 4,3,2 route output group to pairs 0/1, 10/11, 2/3.
// - octal bits 1:0 pick input pair 2/3, 10/11, 8/9; 3 unused.
// - loopback sends each receiver stream straight to its transmitter.
// - loopback returns playback 2/3->10/0, 8/9->2/3, 10/11->11/1.
// - main control bit 0 high enables loopback, test use only.
// - receiver audio packed into octal streams, octal unpacked to tx.
`timescale 1ns/1ps
module acl_router #(
    parameter logic [7:0]  BOARD_ID   = 8'h5a,  // arbitrary value
    parameter int unsigned FIFO_DEPTH = acl_pkg::FIFO_DEPTH
) (
    // clocks and reset
    input  wire logic       ref_clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       link_clk_i,
    // register bus
    input  wire logic       io_as_n_i,
    input  wire logic       io_ds_n_i,
    input  wire logic       io_wr_n_i,
    input  wire logic [8:0] io_addr_i,
    input  wire logic [7:0] io_data_i,
    output logic      [7:0] io_data_o,
    output logic            io_data_oe_o,
    // codec chip selects
    output logic      [3:0] rx_cs_n_o,
    output logic      [3:0] tx_cs_n_o,
    // clock lock
    output logic            seek_mode_o,
    input  wire logic       word_clk_i,
    // receivers
    output logic            rx_bclk_o,
    output logic            rx_lrck_o,
    output logic            rx_clk_oe_o,
    input  wire logic [3:0] rx_sdata_i,
    // transmitters
    output logic            tx_bclk_o,
    output logic            tx_lrck_o,
    output logic      [3:0] tx_sdata_o,
    // octal streams
    input  wire logic [5:0] pb_oct_i,
    output logic      [5:0] cap_oct_o,
    output logic      [5:0] cap_oct_oe_o
);
    localparam int unsigned HALF_W = acl_pkg::CHIPS * acl_pkg::SAMPLE_W;

    typedef logic [acl_pkg::SAMPLE_W-1:0] acl_word_t;

    typedef struct packed {
        logic       ds_prev;
        logic [7:0] main_ctrl;
        logic [7:0] lock;
        logic [7:0] octal;
        logic [7:0] rd_data;
        logic       rd_oe;
        logic [3:0] rx_cs_n;
        logic [3:0] tx_cs_n;
        logic       seek;
    } acl_reg_st_t;

    typedef struct packed {
        logic                                 wclk_prev;
        logic [7:0]                           cnt;
        logic [acl_pkg::CHIPS-1:0][23:0]      rx_sh;
        logic                                 push_valid;
        logic [acl_pkg::CHIPS-1:0][23:0]      push_data;
        logic [acl_pkg::CHIPS-1:0][23:0]      out_half;
        logic [23:0]                          pb_sh;
        logic [acl_pkg::SLOTS-1:0][23:0]      pb_words;
        logic [acl_pkg::SLOTS-1:0][23:0]      tx_words;
        logic [5:0]                           cap;
        logic [5:0]                           cap_oe;
        logic [3:0]                           tx_sd;
        logic                                 bclk;
        logic                                 lrck;
    } acl_link_st_t;

    localparam acl_reg_st_t REG_RST = '{
        ds_prev:   1'b1,
        main_ctrl: acl_pkg::RST_MAIN_CTRL,
        lock:      acl_pkg::RST_LOCK,
        octal:     acl_pkg::RST_OCTAL,
        rx_cs_n:   4'hf,
        tx_cs_n:   4'hf,
        default:   '0
    };

    // true when the address falls in the 32-byte page of device base+idx
    function automatic logic page_hit(input logic [8:0] a,
                                      input logic [8:0] base,
                                      input logic [3:0] idx);
        logic [3:0] pg;
        pg = base[8:acl_pkg::PAGE_LSB] + idx;
        page_hit = (a[8:acl_pkg::PAGE_LSB] == pg);
    endfunction : page_hit

    // msb-first bit of a sample within a 32-bit slot, zero padded
    function automatic logic bit_of(input acl_word_t w,
                                    input logic [4:0] idx);
        logic [4:0] k;
        k = acl_pkg::LAST_BIT - idx;
        bit_of = (idx < acl_pkg::SAMPLE_BITS) ? w[k] : 1'b0;
    endfunction : bit_of

    // ---- register side, ref clock
    acl_pkg::acl_iob_t bus;
    acl_pkg::acl_cfg_t cfg_ref;
    acl_reg_st_t       r_q;
    acl_reg_st_t       r_d;
    logic              sel;
    logic              wr_pulse;
    logic              own_hit;
    logic [7:0]        rd_val;

    acl_sync #(
        .WIDTH ($bits(acl_pkg::acl_iob_t))
    ) u_bus_sync (
        .clk_i (ref_clk_i),
        .d_i   ({io_as_n_i, io_ds_n_i, io_wr_n_i, io_addr_i, io_data_i}),
        .q_o   (bus)
    );

    always_comb begin
        r_d        = r_q;
        sel        = !bus.as_n && !bus.ds_n;
        // a write takes effect once, at the start of the data strobe
        wr_pulse   = sel && r_q.ds_prev && !bus.wr_n;
        r_d.ds_prev = bus.ds_n;
        if (wr_pulse) begin
            case (bus.addr)
                acl_pkg::OFS_MAIN_CTRL: r_d.main_ctrl = bus.data;
                acl_pkg::OFS_LOCK:
                    r_d.lock = bus.data & acl_pkg::LOCK_MASK;
                acl_pkg::OFS_OCTAL:
                    r_d.octal = bus.data & acl_pkg::OCT_MASK;
                default: ;
            endcase
        end
        own_hit = 1'b1;
        case (bus.addr)
            acl_pkg::OFS_BOARD_ID:  rd_val = BOARD_ID;
            acl_pkg::OFS_MAIN_CTRL: rd_val = r_q.main_ctrl;
            acl_pkg::OFS_LOCK:      rd_val = r_q.lock;
            acl_pkg::OFS_OCTAL:     rd_val = r_q.octal;
            default: begin
                rd_val  = 8'h00;
                own_hit = 1'b0;
            end
        endcase
        // codec pages are answered by the codecs themselves
        r_d.rd_oe   = sel && bus.wr_n && own_hit;
        r_d.rd_data = r_d.rd_oe ? rd_val : 8'h00;
        for (int i = 0; i < acl_pkg::CHIPS; i++) begin
            r_d.rx_cs_n[i] = !(!bus.as_n &&
                page_hit(bus.addr, acl_pkg::OFS_RX_BASE, 4'(i)));
            r_d.tx_cs_n[i] = !(!bus.as_n &&
                (page_hit(bus.addr, acl_pkg::OFS_TX_BASE, 4'(i)) ||
                 page_hit(bus.addr, acl_pkg::OFS_TX_GLOBAL,
                          4'h0)));
        end
        r_d.seek = r_q.lock[acl_pkg::LOCK_SEEK_BIT];
        cfg_ref.loopback = r_q.main_ctrl[acl_pkg::CTRL_LOOP_BIT];
        cfg_ref.drive    = r_q.lock[acl_pkg::LOCK_DRIVE_BIT];
        cfg_ref.out_en   = r_q.octal[acl_pkg::OCT_OUT01_BIT:
                                     acl_pkg::OCT_OUT23_BIT];
        cfg_ref.in_sel   = r_q.octal[acl_pkg::OCT_IN_MSB:
                                     acl_pkg::OCT_IN_LSB];
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            r_q <= REG_RST;
        end else begin
            r_q <= r_d;
        end
    end

    assign io_data_o    = r_q.rd_data;
    assign io_data_oe_o = r_q.rd_oe;
    assign rx_cs_n_o    = r_q.rx_cs_n;
    assign tx_cs_n_o    = r_q.tx_cs_n;
    assign seek_mode_o  = r_q.seek;

    // ---- link side, link clock
    // config bits are static between host writes, so per-bit syncing is
    // safe; a routing change may glitch audio for one frame
    acl_pkg::acl_cfg_t cfg;
    logic              lrst_n;
    logic              wclk_s;
    logic [3:0]        rx_s;
    logic [5:0]        pb_s;
    acl_link_st_t      l_q;
    acl_link_st_t      l_d;
    logic              push_ready;
    logic              pop_ready;
    logic              fifo_valid;
    logic [HALF_W-1:0] fifo_data;
    logic              half;
    logic [4:0]        bit_idx;
    logic [1:0]        phase;
    logic [2:0]        slot;
    logic [4:0]        sbit;
    logic              oct_bit;
    logic              pb_line;

    acl_sync #(.WIDTH(1)) u_rst_sync (
        .clk_i (link_clk_i),
        .d_i   (rst_n_i),
        .q_o   (lrst_n)
    );

    acl_sync #(.WIDTH($bits(acl_pkg::acl_cfg_t))) u_cfg_sync (
        .clk_i (link_clk_i),
        .d_i   (cfg_ref),
        .q_o   (cfg)
    );

    acl_sync #(.WIDTH(11)) u_pin_sync (
        .clk_i (link_clk_i),
        .d_i   ({word_clk_i, rx_sdata_i, pb_oct_i}),
        .q_o   ({wclk_s, rx_s, pb_s})
    );

    // half-frame buffer of four receiver samples toward the octal packer
    acl_fifo #(
        .WIDTH (HALF_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_i       (link_clk_i),
        .rst_n_i     (lrst_n),
        .in_valid_i  (l_q.push_valid),
        .in_ready_o  (push_ready),
        .in_data_i   (l_q.push_data),
        .out_valid_o (fifo_valid),
        .out_ready_i (pop_ready),
        .out_data_o  (fifo_data)
    );

    always_comb begin
        l_d     = l_q;
        half    = l_q.cnt[7];
        bit_idx = l_q.cnt[6:2];
        phase   = l_q.cnt[1:0];
        slot    = l_q.cnt[7:5];
        sbit    = l_q.cnt[4:0];
        l_d.wclk_prev = wclk_s;
        l_d.cnt  = (wclk_s && !l_q.wclk_prev) ? 8'h00 : l_q.cnt + 8'h01;
        l_d.bclk = l_q.cnt[1];
        l_d.lrck = l_q.cnt[7];

        // receiver deserialise; a held sample waits for fifo room
        if (push_ready) begin
            l_d.push_valid = 1'b0;
        end
        if (phase == acl_pkg::PH_SAMPLE &&
            bit_idx < acl_pkg::SAMPLE_BITS) begin
            for (int r = 0; r < acl_pkg::CHIPS; r++) begin
                l_d.rx_sh[r] = {l_q.rx_sh[r][22:0], rx_s[r]};
            end
            if (bit_idx == acl_pkg::LAST_BIT) begin
                l_d.push_valid = 1'b1;
                l_d.push_data  = l_d.rx_sh;
            end
        end

        // octal packer: slots 0-3 left samples, 4-7 right samples
        pop_ready = (l_q.cnt[6:0] == 7'h00) && !cfg.loopback &&
                    (cfg.out_en != 3'h0);
        if (pop_ready) begin
            l_d.out_half = fifo_valid ? fifo_data : '0;
        end
        oct_bit = bit_of(l_d.out_half[slot[1:0]], sbit);

        if (cfg.loopback) begin
            l_d.cap[acl_pkg::CAP_L10] = pb_s[acl_pkg::PB_L2];
            l_d.cap[acl_pkg::CAP_L0]  = pb_s[acl_pkg::PB_L3];
            l_d.cap[acl_pkg::CAP_L2]  = pb_s[acl_pkg::PB_L8];
            l_d.cap[acl_pkg::CAP_L3]  = pb_s[acl_pkg::PB_L9];
            l_d.cap[acl_pkg::CAP_L11] = pb_s[acl_pkg::PB_L10];
            l_d.cap[acl_pkg::CAP_L1]  = pb_s[acl_pkg::PB_L11];
            l_d.cap_oe = 6'h3f;
        end else begin
            l_d.cap = 6'h00;
            l_d.cap[acl_pkg::CAP_L0]  = oct_bit & cfg.out_en[2];
            l_d.cap[acl_pkg::CAP_L10] = oct_bit & cfg.out_en[1];
            l_d.cap[acl_pkg::CAP_L2]  = oct_bit & cfg.out_en[0];
            l_d.cap_oe[acl_pkg::CAP_L0]  = cfg.out_en[2];
            l_d.cap_oe[acl_pkg::CAP_L1]  = cfg.out_en[2];
            l_d.cap_oe[acl_pkg::CAP_L10] = cfg.out_en[1];
            l_d.cap_oe[acl_pkg::CAP_L11] = cfg.out_en[1];
            l_d.cap_oe[acl_pkg::CAP_L2]  = cfg.out_en[0];
            l_d.cap_oe[acl_pkg::CAP_L3]  = cfg.out_en[0];
        end

        // playback group select, code 3 plays silence
        case (cfg.in_sel)
            acl_pkg::IN_SEL_23:   pb_line = pb_s[acl_pkg::PB_L2];
            acl_pkg::IN_SEL_1011: pb_line = pb_s[acl_pkg::PB_L10];
            acl_pkg::IN_SEL_89:   pb_line = pb_s[acl_pkg::PB_L8];
            default:              pb_line = 1'b0;
        endcase
        if (sbit < acl_pkg::SAMPLE_BITS) begin
            l_d.pb_sh = {l_q.pb_sh[22:0], pb_line};
        end
        if (sbit == acl_pkg::LAST_BIT) begin
            l_d.pb_words[slot] = {l_q.pb_sh[22:0], pb_line};
        end
        // whole frame is handed over at once so channels stay aligned
        if (l_q.cnt == acl_pkg::FRAME_LAST) begin
            l_d.tx_words = l_q.pb_words;
        end

        if (cfg.loopback) begin
            l_d.tx_sd = rx_s;
        end else if (phase == acl_pkg::PH_LAUNCH) begin
            for (int r = 0; r < acl_pkg::CHIPS; r++) begin
                l_d.tx_sd[r] = bit_of(l_q.tx_words[{half, 2'(r)}],
                                      bit_idx);
            end
        end
    end

    always_ff @(posedge link_clk_i) begin
        if (!lrst_n) begin
            l_q <= '0;
        end else begin
            l_q <= l_d;
        end
    end

    assign rx_bclk_o    = l_q.bclk;
    assign rx_lrck_o    = l_q.lrck;
    assign rx_clk_oe_o  = cfg.drive;
    assign tx_bclk_o    = l_q.bclk;
    assign tx_lrck_o    = l_q.lrck;
    assign tx_sdata_o   = l_q.tx_sd;
    assign cap_oct_o    = l_q.cap;
    assign cap_oct_oe_o = l_q.cap_oe;

endmodule : acl_router

// *** rtl/acl_pkg.sv ***
// constants and carrier types shared by the clock-lock / octal router block
// assumes an 8-bit backplane register bus and a 256fs link clock
package acl_pkg;

    // register bus
    localparam int unsigned ADDR_W        = 9;
    localparam int unsigned DATA_W        = 8;
    localparam int unsigned PAGE_LSB      = 5;
    localparam logic [8:0]  OFS_BOARD_ID  = 9'h000;
    localparam logic [8:0]  OFS_MAIN_CTRL = 9'h020;
    localparam logic [8:0]  OFS_LOCK      = 9'h040;
    localparam logic [8:0]  OFS_TX_GLOBAL = 9'h060;
    localparam logic [8:0]  OFS_OCTAL     = 9'h080;
    localparam logic [8:0]  OFS_RX_BASE   = 9'h100;
    localparam logic [8:0]  OFS_TX_BASE   = 9'h180;

    // reset values
    localparam logic [7:0]  RST_MAIN_CTRL = 8'h00;
    localparam logic [7:0]  RST_LOCK      = 8'h00;
    localparam logic [7:0]  RST_OCTAL     = 8'h00;

    // field positions and writable masks
    localparam int unsigned CTRL_LOOP_BIT   = 0;
    localparam int unsigned LOCK_DRIVE_BIT  = 0;
    localparam int unsigned LOCK_SEEK_BIT   = 1;
    localparam int unsigned OCT_OUT01_BIT   = 4;
    localparam int unsigned OCT_OUT1011_BIT = 3;
    localparam int unsigned OCT_OUT23_BIT   = 2;
    localparam int unsigned OCT_IN_MSB      = 1;
    localparam int unsigned OCT_IN_LSB      = 0;
    localparam logic [7:0]  LOCK_MASK       = 8'h03;
    localparam logic [7:0]  OCT_MASK        = 8'h1f;

    // input group codes
    localparam logic [1:0]  IN_SEL_23   = 2'h0;
    localparam logic [1:0]  IN_SEL_1011 = 2'h1;
    localparam logic [1:0]  IN_SEL_89   = 2'h2;

    // capture line indices (octals 0,1,2,3,10,11)
    localparam int unsigned NUM_LINES = 6;
    localparam int unsigned CAP_L0    = 0;
    localparam int unsigned CAP_L1    = 1;
    localparam int unsigned CAP_L2    = 2;
    localparam int unsigned CAP_L3    = 3;
    localparam int unsigned CAP_L10   = 4;
    localparam int unsigned CAP_L11   = 5;
    // playback line indices (octals 2,3,8,9,10,11)
    localparam int unsigned PB_L2     = 0;
    localparam int unsigned PB_L3     = 1;
    localparam int unsigned PB_L8     = 2;
    localparam int unsigned PB_L9     = 3;
    localparam int unsigned PB_L10    = 4;
    localparam int unsigned PB_L11    = 5;

    // audio framing, in link clock cycles
    localparam int unsigned SAMPLE_W    = 24;
    localparam int unsigned SLOTS       = 8;
    localparam int unsigned CHIPS       = 4;
    localparam int unsigned FIFO_DEPTH  = 8;
    localparam logic [4:0]  SAMPLE_BITS = 5'd24;
    localparam logic [4:0]  LAST_BIT    = 5'd23;
    localparam logic [1:0]  PH_SAMPLE   = 2'h3;
    localparam logic [1:0]  PH_LAUNCH   = 2'h0;
    localparam logic [7:0]  FRAME_LAST  = 8'hff;

    typedef struct packed {
        logic       as_n;
        logic       ds_n;
        logic       wr_n;
        logic [8:0] addr;
        logic [7:0] data;
    } acl_iob_t;

    typedef struct packed {
        logic       loopback;
        logic       drive;
        logic [2:0] out_en;   // [2] octals 0/1, [1] 10/11, [0] 2/3
        logic [1:0] in_sel;
    } acl_cfg_t;

endpackage : acl_pkg

// *** rtl/acl_sync.sv ***
// two-flop synchroniser for levels and quasi-static words
// assumes each bit is stable long enough to be caught; no word coherence
`timescale 1ns/1ps
module acl_sync #(
    parameter int unsigned WIDTH = 1
) (
    // clock
    input  wire logic             clk_i,
    // data
    input  wire logic [WIDTH-1:0] d_i,
    output logic      [WIDTH-1:0] q_o
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] sync;
    } acl_sync_st_t;

    acl_sync_st_t s_q;
    acl_sync_st_t s_d;

    if (WIDTH < 1) begin : g_bad_width
        $error("acl_sync: WIDTH must be at least 1");
    end

    always_comb begin
        s_d      = s_q;
        s_d.meta = d_i;
        s_d.sync = s_q.meta;
    end

    // no reset: the stages only carry the input
    always_ff @(posedge clk_i) begin
        s_q <= s_d;
    end

    assign q_o = s_q.sync;

endmodule : acl_sync

// *** rtl/acl_fifo.sv ***
// single-clock fifo with valid/ready on both sides
// assumes DEPTH is a power of two; output word comes from storage flops
`timescale 1ns/1ps
module acl_fifo #(
    parameter int unsigned WIDTH = 96,
    parameter int unsigned DEPTH = 8
) (
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    // fill side
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    // drain side
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);
    localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad
        $error("acl_fifo: DEPTH must be a power of two >= 2");
    end

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW:0]                 wr;
        logic [AW:0]                 rd;
    } acl_fifo_st_t;

    acl_fifo_st_t s_q;
    acl_fifo_st_t s_d;
    logic         full;
    logic         empty;

    assign full        = (s_q.wr[AW] != s_q.rd[AW]) &&
                         (s_q.wr[AW-1:0] == s_q.rd[AW-1:0]);
    assign empty       = (s_q.wr == s_q.rd);
    assign in_ready_o  = !full;
    assign out_valid_o = !empty;
    assign out_data_o  = s_q.mem[s_q.rd[AW-1:0]];

    always_comb begin
        s_d = s_q;
        if (in_valid_i && !full) begin
            s_d.mem[s_q.wr[AW-1:0]] = in_data_i;
            s_d.wr = s_q.wr + 1'b1;
        end
        if (out_ready_i && !empty) begin
            s_d.rd = s_q.rd + 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

endmodule : acl_fifo

// *** dv/acl_router_assertions.sv ***
// concurrent checks on the router's bus, select and lock ports
// assumes bus strobes are held well past the two-flop sync lag
`timescale 1ns/1ps
module acl_router_assertions (
    // clock and reset
    input wire logic       ref_clk_i,
    input wire logic       rst_n_i,
    // register bus
    input wire logic       io_as_n_i,
    input wire logic       io_ds_n_i,
    input wire logic       io_wr_n_i,
    input wire logic [8:0] io_addr_i,
    input wire logic [7:0] io_data_i,
    input wire logic [7:0] io_data_o,
    input wire logic       io_data_oe_o,
    // selects and lock
    input wire logic [3:0] tx_cs_n_o,
    input wire logic       seek_mode_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);
    sequence s_sel(logic [8:0] a);
        (!io_as_n_i && io_addr_i == a) [*5];
    endsequence
    sequence s_wr_lock(logic b);
        (!io_ds_n_i && !io_wr_n_i && io_addr_i == acl_pkg::OFS_LOCK
            && io_data_i[acl_pkg::LOCK_SEEK_BIT] == b) [*6];
    endsequence
    sequence s_rd(logic [8:0] a);
        (!io_as_n_i && !io_ds_n_i && io_wr_n_i && io_addr_i == a) [*6];
    endsequence
    a_tx_bcast: assert property (
        s_sel(acl_pkg::OFS_TX_GLOBAL) |-> tx_cs_n_o == 4'h0)
        else $error("broadcast select missing");
    a_tx_single: assert property (
        s_sel(acl_pkg::OFS_TX_BASE) |-> tx_cs_n_o == 4'he)
        else $error("single transmitter select wrong");
    a_seek_set: assert property (
        s_wr_lock(1'b1) |-> seek_mode_o)
        else $error("seek mode not entered");
    a_seek_clear: assert property (
        s_wr_lock(1'b0) |-> !seek_mode_o)
        else $error("seek mode not left");
    a_seek_cause: assert property (
        $changed(seek_mode_o) |-> !io_wr_n_i
            && io_addr_i == acl_pkg::OFS_LOCK)
        else $error("seek mode moved without a lock write");
    a_lock_read: assert property (
        s_rd(acl_pkg::OFS_LOCK) |-> io_data_oe_o && io_data_o[7:2] == 6'h00)
        else $error("lock read shows unused bits");
    a_oct_read: assert property (
        s_rd(acl_pkg::OFS_OCTAL) |-> io_data_oe_o && io_data_o[7:5] == 3'h0)
        else $error("octal read shows unused bits");
    a_oe_read: assert property (
        io_data_oe_o |-> io_wr_n_i && $past(io_wr_n_i, 2))
        else $error("read data driven during a write");
endmodule : acl_router_assertions

bind acl_router acl_router_assertions u_chk (.ref_clk_i, .rst_n_i,
    .io_as_n_i, .io_ds_n_i, .io_wr_n_i, .io_addr_i, .io_data_i,
    .io_data_o, .io_data_oe_o, .tx_cs_n_o, .seek_mode_o);

// *** dv/acl_host_model.sv ***
// host card bus master model for the router block
// assumes the bench calls acc; strobes move on ref clock falling edges
`timescale 1ns/1ps
module acl_host_model (
    // clock
    input  wire logic       clk_i,
    // bus
    output logic            as_n_o,
    output logic            ds_n_o,
    output logic            wr_n_o,
    output logic      [8:0] addr_o,
    output logic      [7:0] data_o,
    input  wire logic [7:0] data_i
);
    initial begin
        {as_n_o, ds_n_o, wr_n_o} = 3'h7;
        addr_o = 9'h1ff;
        data_o = 8'h00;
    end
    // a whole access fits well inside one word period
    task automatic acc(input logic wr, input logic [8:0] a,
                       input logic [7:0] d, output logic [7:0] q);
        @(negedge clk_i);
        {as_n_o, ds_n_o, wr_n_o} = {2'b00, !wr};
        addr_o = a;
        data_o = d;
        repeat (7) @(negedge clk_i);
        q = data_i;
        {as_n_o, ds_n_o, wr_n_o} = 3'h7;
        // released lines must not keep showing the old value
        addr_o = ~a;
        data_o = ~d;
        repeat (5) @(negedge clk_i);
    endtask : acc
endmodule : acl_host_model

// *** dv/acl_router_tb.sv ***
// self-checking bench for the clock-lock and octal router
// assumes the host model and the bound checker are compiled first
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin \
    fail_count++; $display("[FAIL] %0t %h != %h", $time, g, e); end end
module acl_router_tb;
    logic       ref_clk, link_clk, rst_n, as_n, ds_n, wr_n, oe, seek, rx_oe;
    logic [7:0] word_cnt, wdat, rdat, q;
    logic [8:0] addr;
    logic [3:0] tx_cs_n, rx_cs_n, rx_sd, tx_sd;
    logic [5:0] pb, cap, cap_oe, exp6;
    int         fail_count = 0;
    int         cmp_count = 0;

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    initial begin
        link_clk = 1'b0;
        #3.3;
        forever #7.5 link_clk = ~link_clk;
    end
    // word clock runs free at 1/256 of the link clock
    always @(negedge link_clk) word_cnt <= word_cnt + 8'h01;

    acl_router u_dut (
        .ref_clk_i(ref_clk), .rst_n_i(rst_n), .link_clk_i(link_clk),
        .io_as_n_i(as_n), .io_ds_n_i(ds_n), .io_wr_n_i(wr_n),
        .io_addr_i(addr), .io_data_i(wdat), .io_data_o(rdat),
        .io_data_oe_o(oe), .rx_cs_n_o(rx_cs_n), .tx_cs_n_o(tx_cs_n),
        .seek_mode_o(seek), .word_clk_i(word_cnt[7]), .rx_bclk_o(),
        .rx_lrck_o(), .rx_clk_oe_o(rx_oe), .rx_sdata_i(rx_sd),
        .tx_bclk_o(), .tx_lrck_o(), .tx_sdata_o(tx_sd),
        .pb_oct_i(pb), .cap_oct_o(cap), .cap_oct_oe_o(cap_oe));
    acl_host_model u_host (.clk_i(ref_clk), .as_n_o(as_n), .ds_n_o(ds_n),
        .wr_n_o(wr_n), .addr_o(addr), .data_o(wdat), .data_i(rdat));

    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        u_host.acc(1'b1, a, d, q);
    endtask : wr
    task automatic rd_chk(input logic [8:0] a, input logic [7:0] e);
        u_host.acc(1'b0, a, 8'h00, q);
        `CHK(q, e)
    endtask : rd_chk
    task automatic wr_cs(input logic [8:0] a, input logic [7:0] d,
                         input logic [7:0] e);
        fork
            wr(a, d);
            begin
                repeat (6) @(negedge ref_clk);
                `CHK({rx_cs_n, tx_cs_n}, e)
            end
        join
    endtask : wr_cs
    task automatic t_reset;
        `CHK({seek, rx_oe}, 2'b00)
        rd_chk(acl_pkg::OFS_LOCK, 8'h00);
        rd_chk(acl_pkg::OFS_OCTAL, 8'h00);
        $display("t_reset done");
    endtask : t_reset
    task automatic t_lock;
        wr(acl_pkg::OFS_LOCK, 8'h02); // clocks off, seek on
        `CHK(seek, 1'b1)
        wr_cs(acl_pkg::OFS_RX_BASE + 9'h020, 8'h02, 8'hdf); // master
        wr(acl_pkg::OFS_LOCK, 8'hfe);
        `CHK(rx_oe, 1'b0)
        rd_chk(acl_pkg::OFS_LOCK, 8'h02);
        repeat (40) @(negedge ref_clk); // shortened master dwell
        wr(acl_pkg::OFS_LOCK, 8'h00);
        `CHK(seek, 1'b0)
        wr_cs(acl_pkg::OFS_RX_BASE + 9'h020, 8'h00, 8'hdf); // slave
        wr(acl_pkg::OFS_LOCK, 8'h01);
        repeat (4) @(negedge link_clk);
        `CHK({seek, rx_oe}, 2'b01)
        $display("t_lock done");
    endtask : t_lock
    task automatic t_txcs;
        logic [8:0] a;
        logic [7:0] e;
        for (int i = 0; i < 5; i++) begin
            a = (i == 4) ? acl_pkg::OFS_TX_GLOBAL
                         : acl_pkg::OFS_TX_BASE + 9'(i * 32);
            e = {4'hf, (i == 4) ? 4'h0 : ~(4'h1 << i)};
            wr_cs(a, 8'h00, e);
        end
        $display("t_txcs done");
    endtask : t_txcs
    task automatic t_octal;
        logic [2:0] v;
        for (int i = 0; i < 8; i++) begin
            v = 3'(i);
            wr(acl_pkg::OFS_OCTAL, {3'h7, v, v[1:0]});
            rd_chk(acl_pkg::OFS_OCTAL, {3'h0, v, v[1:0]});
            repeat (4) @(negedge link_clk);
            `CHK(cap_oe, {{2{v[1]}}, {2{v[0]}}, {2{v[2]}}})
        end
        wr(acl_pkg::OFS_OCTAL, 8'h00);
        $display("t_octal done");
    endtask : t_octal
    task automatic t_play;
        rx_sd = 4'hf;
        for (int i = 0; i < 8; i++) begin
            // octals 8,10 then 2,10 carry ones; pair 2/3 routed out
            pb = i[2] ? 6'h11 : 6'h14;
            wr(acl_pkg::OFS_OCTAL, 8'h04 | 8'(i[1:0]));
            repeat (2) @(posedge word_cnt[7]);
            wait (word_cnt == 8'h30);
            exp6 = {6{i[1:0] == 2'h1 || i[1:0] == (i[2] ? 2'h0 : 2'h2)}};
            `CHK(tx_sd, exp6[3:0])
            // stale fifo words need a few frames to drain first
            if (i[2]) `CHK(cap, 6'h04)
        end
        $display("t_play done");
    endtask : t_play
    task automatic t_loop;
        wr(acl_pkg::OFS_MAIN_CTRL, 8'h01);
        for (int i = 0; i < 3; i++) begin
            @(negedge link_clk);
            pb = 6'(6'h2d << i);
            rx_sd = 4'(4'h5 << i);
            repeat (6) @(negedge link_clk);
            // capture octals 0,1,2,3,10,11 take playback 3,11,8,9,2,10
            exp6 = {pb[4], pb[0], pb[3], pb[2], pb[5], pb[1]};
            `CHK(cap, exp6)
            `CHK(cap_oe, 6'h3f)
            `CHK(tx_sd, rx_sd)
        end
        wr(acl_pkg::OFS_MAIN_CTRL, 8'h00);
        $display("t_loop done");
    endtask : t_loop
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_of_test

    initial begin
        rst_n = 1'b0;
        word_cnt = 8'h00;
        pb = 6'h00;
        rx_sd = 4'h0;
        repeat (12) @(negedge ref_clk);
        rst_n = 1'b1;
        repeat (4) @(negedge ref_clk);
        t_reset();
        t_lock();
        t_lock(); // lock again, starting with clocks driven and seek off
        t_txcs();
        t_octal();
        t_play();
        t_loop();
        end_of_test();
    end
    initial begin
        #300us;
        fail_count++;
        end_of_test();
    end
endmodule : acl_router_tb
